// ===== inc/fpga_config_loader_consts.svh
/*
 Constants for the configuration loader: timing, bitstream layout, buffer size.
 Assumes a 50 MHz core clock; included by its bare name.
*/
// Summary of operation
// - Stream opens with fill ones, preamble 11110010, 24-bit length count, fill ones.
// - Frame is start bit 0, data, CRC bits, stop bits 111; ones postamble.
// - Frames loaded per device range from 430 to 720 by capacity.
// - Mode pins 2,1,0: master 000, slave 111, sync 011, async 101, JTAG 001.
// - Restart low clears configuration memory and waits; power-up starts automatically.
// - Restart rising edge clears memory, drives init low, samples mode, drives done low.
// - Init line released high once ready for configuration data.
// - Bitstream error pulls the open-drain init line low again.
// - Open-drain done line low until fully configured; pull-up gives high.
// - Master and async modes drive the config clock; slave and sync take it in.
// - Serial modes read data bit 0; peripheral modes read bytes on bits 0-7.
// - Chain leader loads itself, then passes further data on the chain output.
// - Peripheral modes show ready/busy on its own pin and on data bit 7.
// - While loading one status pin is high, another low; afterwards user I/O.
// - Sync mode host clocks each byte; device serializes it into memory.
// - Chain loaded in peripheral mode: followers run in slave serial mode.
// - Done and init lines answer a restart pulse within 1.0 us.
// - First config clock at least 1.0 us after init; master starts 200-900 ns.
// - Bit count follows the header; in a chain it covers all programs.
// - Every config clock counts one bit; done rises when count equals length.
// - After an error only a new restart pulse begins loading again.
`ifndef FPGA_CONFIG_LOADER_CONSTS_SVH
`define FPGA_CONFIG_LOADER_CONSTS_SVH

`define MCLK_MHZ 50
`define T_INIT_NS 30000
`define INIT_CYC ((`T_INIT_NS * `MCLK_MHZ + 999) / 1000)
`define T_MSTART_NS 200
`define MSTART_CYC ((`T_MSTART_NS * `MCLK_MHZ + 999) / 1000)
`define T_RESP_NS 1000
`define RESP_CYC ((`T_RESP_NS * `MCLK_MHZ) / 1000)
`define PREAMBLE 8'hf2
`define LEN_BITS 24
`define CRC_BITS 16
`define STOP_BITS 3
`define FRAME_DATA_BITS 560
`define FRAME_COUNT_DEF 430
`define CRC_POLY 16'h8005
`define CONFIG_CLOCK_SAMPLE 3'h6
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`define SYNC_IDLE 17'h0000c

`endif

// ===== inc/fpga_config_loader_pkg.sv
/*
 Types for the configuration loader: loader states and mode pin codes.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fpga_config_loader_pkg;
    typedef enum logic [3:0] {
        ST_WAIT = 4'h0, ST_INIT = 4'h1, ST_PRE = 4'h2, ST_LEN = 4'h3,
        ST_HUNT = 4'h4, ST_DATA = 4'h5, ST_CRC = 4'h6, ST_STOP = 4'h7,
        ST_FWD = 4'h8, ST_DONE = 4'h9, ST_ERR = 4'ha
    } load_state_e;
    typedef enum logic [2:0] {
        MODE_MSER = 3'h0, MODE_JTAG = 3'h1, MODE_SPER = 3'h3,
        MODE_APER = 3'h5, MODE_SSER = 3'h7
    } cfg_mode_e;
endpackage

// ===== rtl/fpga_config_loader.sv
/*
 Configuration loader: restart and init handshake, mode capture, direct serial intake or byte
 intake through a byte FIFO, bitstream parsing with frame CRC, chain forwarding.
 Assumes every pin is asynchronous to i_mclk and wired-or lines resolved outside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fpga_config_loader_consts.svh"

module byte_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW:0] wp_q, rp_q;
    wire push = i_in_valid & o_in_ready;
    wire pop = o_out_valid & i_out_ready;
    assign o_in_ready = (wp_q[AW-1:0] != rp_q[AW-1:0]) || (wp_q[AW] == rp_q[AW]);
    assign o_out_valid = wp_q != rp_q;
    assign o_out_data = mem_q[rp_q[AW-1:0]];
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
        end else if (i_flush) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_q + (AW+1)'(push);
            rp_q <= rp_q + (AW+1)'(pop);
        end
    end
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= i_in_data;
        end
    end
endmodule

module fpga_config_loader
    import fpga_config_loader_pkg::*;
#(
    parameter int FRAME_COUNT = `FRAME_COUNT_DEF
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_restart_b,
    input wire logic [2:0] i_mode,
    input wire logic i_cfg_clk,
    input wire logic [7:0] i_din,
    input wire logic i_wr_b,
    input wire logic i_rd_b,
    input wire logic i_init_pin,
    input wire logic i_done_pin,
    output logic o_cfg_clk,
    output logic o_cfg_clk_oe,
    output logic o_init_o,
    output logic o_init_oe,
    output logic o_done_o,
    output logic o_done_oe,
    output logic o_dout,
    output logic o_rdy_busy,
    output logic o_din7,
    output logic o_din7_oe,
    output logic o_high_while_loading,
    output logic o_high_oe,
    output logic o_low_while_loading,
    output logic o_low_oe,
    output logic o_mem_clear,
    output logic o_cfg_bit,
    output logic o_cfg_bit_valid,
    output logic o_frame_ok,
    output logic [2:0] o_mode
);
    localparam int RESP_MAX = `RESP_CYC;
    localparam logic [10:0] INIT_LAST = 11'(`INIT_CYC - 1);
    localparam logic [10:0] MSTART_LAST = 11'(`MSTART_CYC - 1);
    localparam logic [9:0] LEN_LAST = 10'(`LEN_BITS - 1);
    localparam logic [9:0] DATA_LAST = 10'(`FRAME_DATA_BITS - 1);
    localparam logic [9:0] CRC_LAST = 10'(`CRC_BITS - 1);
    localparam logic [9:0] STOP_LAST = 10'(`STOP_BITS - 1);
    localparam logic [9:0] FRAME_LAST = 10'(FRAME_COUNT - 1);

    // Pin synchronisers; first stage feeds only the second
    logic [16:0] s1_q, s2_q, sp_q;
    wire [16:0] pins = {i_restart_b, i_mode, i_cfg_clk, i_din, i_wr_b, i_rd_b,
                        i_init_pin, i_done_pin};
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= `SYNC_IDLE;
            s2_q <= `SYNC_IDLE;
            sp_q <= `SYNC_IDLE;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            sp_q <= s2_q;
        end
    end
    wire restart_s = s2_q[16];
    wire [2:0] mode_s = s2_q[15:13];
    wire [7:0] din_s = s2_q[11:4];
    wire rd_b_s = s2_q[2];
    wire init_s = s2_q[1];
    wire done_s = s2_q[0];
    wire config_clock_rise = s2_q[12] & ~sp_q[12];
    wire wr_fall = ~s2_q[3] & sp_q[3];

    load_state_e state_q, state_d;
    cfg_mode_e mode_q;
    logic [23:0] sh_q, len_q, bit_cnt_q;
    logic [15:0] crc_q;
    logic [9:0] cnt_q, frame_cnt_q;
    logic [10:0] wait_q;
    logic [7:0] ser_q;
    logic [3:0] ser_n_q;
    logic [2:0] div_q;
    logic len_ok_q, start_ok_q, config_clock_q, dout_q, cfg_bit_q, cfg_valid_q, frame_ok_q;

    wire loading = (state_q >= ST_PRE) && (state_q <= ST_FWD);
    wire is_master = mode_q == MODE_MSER;
    wire is_slave = mode_q == MODE_SSER;
    wire is_sync = mode_q == MODE_SPER;
    wire is_async = mode_q == MODE_APER;
    wire periph = is_sync | is_async;
    wire dev_clk = is_master | is_async;

    // Byte intake; host must wait for ready, a byte offered while full is lost
    logic fifo_in_rdy, fifo_out_vld;
    logic [7:0] fifo_data;
    wire ser_empty = ser_n_q == 4'h0;
    wire fifo_pop = loading & ser_empty;
    wire push = loading & (is_async ? wr_fall : (is_sync & config_clock_rise));
    byte_fifo #(.W(`FIFO_WIDTH), .D(`FIFO_DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_flush(~loading),
        .i_in_valid(push),
        .o_in_ready(fifo_in_rdy),
        .i_in_data(din_s),
        .o_out_valid(fifo_out_vld),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_data)
    );
    assign o_rdy_busy = loading & periph & fifo_in_rdy;
    assign o_din7 = o_rdy_busy;
    assign o_din7_oe = loading & periph & ~rd_b_s;

    // Internal clock runs only while it has a bit to move
    wire run_int = loading & (is_master ? start_ok_q : (periph & ~ser_empty));
    wire gen_tick = run_int & (div_q == `CONFIG_CLOCK_SAMPLE);
    wire bit_tick = loading & (is_slave ? config_clock_rise : gen_tick);
    wire bit_val = periph ? ser_q[7] : din_s[0];
    wire [23:0] sh_next = {sh_q[22:0], bit_val};
    wire [23:0] bit_cnt_d = bit_cnt_q + 24'h1;
    wire [15:0] crc_next = {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ bit_val) ? `CRC_POLY : 16'h0);
    wire frame_good = (state_q == ST_STOP) & bit_tick & bit_val & (cnt_q == STOP_LAST);
    wire wait_run = (state_q == ST_INIT) | (loading & init_s & ~start_ok_q);
    // Start on a window boundary, else a sample tick could come before any clock edge
    wire start_hit = init_s & (wait_q >= MSTART_LAST) & (div_q == 3'h7);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_WAIT: if (restart_s) state_d = ST_INIT;
            ST_INIT: if (wait_q == INIT_LAST) state_d = ST_PRE;
            ST_PRE: if (bit_tick && sh_next[7:0] == `PREAMBLE) state_d = ST_LEN;
            ST_LEN: if (bit_tick && cnt_q == LEN_LAST) state_d = ST_HUNT;
            ST_HUNT: if (bit_tick && !bit_val) state_d = ST_DATA;
            ST_DATA: if (bit_tick && cnt_q == DATA_LAST) state_d = ST_CRC;
            ST_CRC: begin
                if (bit_tick && cnt_q == CRC_LAST) begin
                    state_d = (sh_next[15:0] == crc_q) ? ST_STOP : ST_ERR;
                end
            end
            ST_STOP: begin
                if (bit_tick && !bit_val) begin
                    state_d = ST_ERR;
                end else if (frame_good) begin
                    state_d = (frame_cnt_q == FRAME_LAST) ? ST_FWD : ST_HUNT;
                end
            end
            ST_FWD: state_d = ST_FWD;
            ST_DONE: state_d = ST_DONE;
            ST_ERR: state_d = ST_ERR;
            default: state_d = ST_WAIT;
        endcase
        if (bit_tick && len_ok_q && bit_cnt_d == len_q && state_d != ST_ERR) begin
            state_d = ST_DONE;
        end
        if (!restart_s) begin
            state_d = ST_WAIT;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_WAIT;
            mode_q <= MODE_MSER;
            cnt_q <= 10'h0;
            wait_q <= 11'h0;
            start_ok_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_WAIT && restart_s) begin
                mode_q <= cfg_mode_e'(mode_s);
            end
            cnt_q <= (state_d != state_q) ? 10'h0 : cnt_q + 10'(bit_tick);
            wait_q <= (state_d != state_q || !wait_run) ? 11'h0 : wait_q + 11'h1;
            start_ok_q <= loading & (start_ok_q | start_hit);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sh_q <= 24'h0;
            len_q <= 24'h0;
            len_ok_q <= 1'b0;
            bit_cnt_q <= 24'h0;
            crc_q <= 16'h0;
            frame_cnt_q <= 10'h0;
        end else begin
            if (bit_tick) begin
                sh_q <= sh_next;
                bit_cnt_q <= bit_cnt_d;
            end
            if (state_q == ST_LEN && bit_tick && cnt_q == LEN_LAST) begin
                len_q <= sh_next;
                len_ok_q <= 1'b1;
            end
            if (state_q == ST_HUNT) begin
                crc_q <= 16'h0;
            end else if (state_q == ST_DATA && bit_tick) begin
                crc_q <= crc_next;
            end
            if (frame_good) begin
                frame_cnt_q <= frame_cnt_q + 10'h1;
            end
            if (!loading) begin
                len_ok_q <= 1'b0;
                bit_cnt_q <= 24'h0;
                frame_cnt_q <= 10'h0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_q <= 3'h0;
            config_clock_q <= 1'b0;
            ser_q <= 8'h0;
            ser_n_q <= 4'h0;
        end else begin
            div_q <= div_q + 3'h1;
            config_clock_q <= run_int & ~div_q[2];
            if (!loading) begin
                ser_n_q <= 4'h0;
            end else if (ser_empty && fifo_out_vld) begin
                ser_q <= fifo_data;
                ser_n_q <= 4'h8;
            end else if (periph && gen_tick) begin
                ser_q <= {ser_q[6:0], 1'b0};
                ser_n_q <= ser_n_q - 4'h1;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dout_q <= 1'b1;
            cfg_bit_q <= 1'b0;
            cfg_valid_q <= 1'b0;
            frame_ok_q <= 1'b0;
        end else begin
            if (state_q == ST_FWD && bit_tick) begin
                dout_q <= bit_val;
            end
            cfg_bit_q <= bit_val;
            cfg_valid_q <= (state_q == ST_DATA) & bit_tick;
            frame_ok_q <= frame_good;
        end
    end

    assign o_cfg_clk = config_clock_q;
    assign o_cfg_clk_oe = dev_clk & (state_q != ST_WAIT);
    assign o_init_o = 1'b0;
    assign o_init_oe = (state_q == ST_WAIT) | (state_q == ST_INIT) | (state_q == ST_ERR);
    assign o_done_o = 1'b0;
    assign o_done_oe = state_q != ST_DONE;
    assign o_dout = dout_q;
    // Released once the done line reads high, so a chain finishes together
    assign o_high_while_loading = 1'b1;
    assign o_high_oe = ~done_s & (state_q != ST_WAIT);
    assign o_low_while_loading = 1'b0;
    assign o_low_oe = ~done_s & (state_q != ST_WAIT);
    assign o_mem_clear = (state_q == ST_WAIT) | (state_q == ST_INIT);
    assign o_cfg_bit = cfg_bit_q;
    assign o_cfg_bit_valid = cfg_valid_q;
    assign o_frame_ok = frame_ok_q;
    assign o_mode = mode_q;

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    restart_resp_a: assert property ($fell(i_restart_b) |-> ##[1:RESP_MAX] (o_init_oe && o_done_oe))
        else $error("restart not answered in time");
    wait_clear_a: assert property ((!restart_s) [*2] |-> o_mem_clear && state_q == ST_WAIT)
        else $error("memory not cleared while restart low");
    mode_sample_a: assert property ((state_q == ST_WAIT && restart_s) |=> (o_mode == $past(mode_s) && o_init_oe))
        else $error("mode not sampled on restart release");
    init_release_a: assert property ((state_q == ST_INIT && restart_s && wait_q == INIT_LAST) |=> !o_init_oe)
        else $error("init line not released");
    error_init_a: assert property ((state_q == ST_CRC && state_d == ST_ERR) |=> (o_init_oe && o_done_oe))
        else $error("error did not pull init low");
    done_count_a: assert property ($rose(state_q == ST_DONE) |-> (bit_cnt_q == len_q && !o_done_oe))
        else $error("done raised at wrong count");
    config_clock_dir_a: assert property ((state_q != ST_WAIT && (is_slave || is_sync)) |-> !o_cfg_clk_oe)
        else $error("config clock driven in input mode");
    preamble_a: assert property ((state_q == ST_PRE && state_d == ST_LEN) |-> sh_next[7:0] == `PREAMBLE)
        else $error("length entered without preamble");
    stop_err_a: assert property ((state_q == ST_STOP && bit_tick && !bit_val && restart_s) |=> state_q == ST_ERR)
        else $error("bad stop bit not flagged");
    frame_cnt_a: assert property ($rose(state_q == ST_FWD) |-> frame_cnt_q == 10'(FRAME_COUNT))
        else $error("forwarding before all frames");
    stay_err_a: assert property ((state_q == ST_ERR && restart_s) |=> state_q == ST_ERR)
        else $error("loader left error by itself");
endmodule
`default_nettype wire

// ===== tb/cfg_host_model.sv
/*
 Host and serial PROM model on the far side of the loader's config port.
 Assumes the bench resolves the shared wires and raises i_go once per load.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fpga_config_loader_consts.svh"
module cfg_host_model
    import fpga_config_loader_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_go,
    input wire logic i_bad,
    input wire logic [2:0] i_mode,
    input wire logic i_dev_clk,
    input wire logic i_init_pin,
    input wire logic i_rdy_busy,
    output logic o_cfg_clk,
    output logic [7:0] o_din,
    output logic o_wr_b
);
    logic s [0:1231];
    logic [15:0] crc;
    logic [23:0] len = 24'd1224;
    logic [7:0] pre = `PREAMBLE;
    int k;
    task automatic put(logic b);
        s[k] = b;
        k++;
    endtask
    task automatic build();
        logic d;
        k = 0;
        for (int i = 0; i < 8; i++) put(1'b1);
        for (int i = 7; i >= 0; i--) put(pre[i]);
        for (int i = 23; i >= 0; i--) put(len[i]);
        for (int i = 0; i < 8; i++) put(1'b1);
        for (int f = 0; f < 2; f++) begin
            put(1'b0);
            crc = 16'h0000;
            for (int j = 0; j < `FRAME_DATA_BITS; j++) begin
                d = ((f * `FRAME_DATA_BITS + j) % 3) == 0;
                put(d);
                crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d) ? `CRC_POLY : 16'h0000);
            end
            crc[0] = crc[0] ^ (i_bad && f == 0);
            for (int i = 15; i >= 0; i--) put(crc[i]);
            for (int i = 0; i < 3; i++) put(1'b1);
        end
        // Word for the next device in the chain
        for (int i = 15; i >= 0; i--) put(i[0]);
        for (int i = 0; i < 8; i++) put(1'b1);
    endtask
    task automatic play();
        if (i_mode != MODE_JTAG) begin
            @(posedge i_init_pin);
            if (i_mode != MODE_MSER) #1000;
            for (int n = 0; n < 1232; n++) begin
                if (i_mode == MODE_MSER) begin
                    @(posedge i_dev_clk);
                    #1 o_din[0] = s[n];
                end else if (i_mode == MODE_SSER) begin
                    o_din[0] = s[n];
                    #80 o_cfg_clk = 1'b1;
                    #80 o_cfg_clk = 1'b0;
                end else if (n % 8 == 0) begin
                    @(posedge i_mclk);
                    while (i_rdy_busy !== 1'b1) @(posedge i_mclk);
                    #1;
                    for (int i = 0; i < 8; i++) o_din[7 - i] = s[n + i];
                    if (i_mode == MODE_APER) begin
                        o_wr_b = 1'b0;
                        repeat (4) @(posedge i_mclk);
                        #1 o_wr_b = 1'b1;
                        repeat (4) @(posedge i_mclk);
                    end else begin
                        #80 o_cfg_clk = 1'b1;
                        #80 o_cfg_clk = 1'b0;
                    end
                end
            end
            // Released data lines must not look like valid data
            o_din = ~o_din;
        end
    endtask
    initial begin
        o_cfg_clk = 1'b0;
        o_din = 8'hff;
        o_wr_b = 1'b1;
        forever begin
            @(posedge i_go);
            build();
            fork
                play();
                @(negedge i_go);
            join_any
            disable fork;
            o_cfg_clk = 1'b0;
            o_wr_b = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb_fpga_config_loader.sv
/*
 Self-checking bench for the loader: one full load per non-JTAG mode row, then a reset and a bad-CRC load.
 Assumes pull-ups on the init and done wires and the host model beside it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fpga_config_loader_consts.svh"
module tb_fpga_config_loader import fpga_config_loader_pkg::*;;
    typedef struct {cfg_mode_e m; logic drv; logic fin;} row_s;
    row_s rows [5] = '{'{MODE_JTAG, 1'b0, 1'b0}, '{MODE_MSER, 1'b1, 1'b1},
        '{MODE_SSER, 1'b0, 1'b1}, '{MODE_APER, 1'b1, 1'b1}, '{MODE_SPER, 1'b0, 1'b1}};
    logic i_mclk, i_rst_b, i_restart_b, i_rd_b, go, bad, h_clk, h_wr_b, dout_q, seen;
    logic cfg_w, init_w, done_w;
    logic [2:0] i_mode, o_mode;
    logic [7:0] h_din, din_w;
    logic o_cfg_clk, o_cfg_clk_oe, o_init_o, o_init_oe, o_done_o, o_done_oe, o_dout;
    logic o_rdy_busy, o_din7, o_din7_oe, o_high_while_loading, o_high_oe, o_low_while_loading;
    logic o_low_oe, o_mem_clear, o_cfg_bit, o_cfg_bit_valid, o_frame_ok;
    int fails, total_checks, nfr, nbit, nfall, nerr, gap, t;
    assign cfg_w = o_cfg_clk_oe ? o_cfg_clk : h_clk;
    assign din_w = {o_din7_oe ? o_din7 : h_din[7], h_din[6:0]};
    assign init_w = o_init_oe ? o_init_o : 1'b1;
    assign done_w = o_done_oe ? o_done_o : 1'b1;
    fpga_config_loader #(.FRAME_COUNT(2)) u_fpga_config_loader (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_restart_b(i_restart_b), .i_mode(i_mode),
        .i_cfg_clk(cfg_w), .i_din(din_w), .i_wr_b(h_wr_b), .i_rd_b(i_rd_b),
        .i_init_pin(init_w), .i_done_pin(done_w), .o_cfg_clk(o_cfg_clk),
        .o_cfg_clk_oe(o_cfg_clk_oe), .o_init_o(o_init_o), .o_init_oe(o_init_oe),
        .o_done_o(o_done_o), .o_done_oe(o_done_oe), .o_dout(o_dout), .o_rdy_busy(o_rdy_busy),
        .o_din7(o_din7), .o_din7_oe(o_din7_oe), .o_high_while_loading(o_high_while_loading),
        .o_high_oe(o_high_oe), .o_low_while_loading(o_low_while_loading), .o_low_oe(o_low_oe),
        .o_mem_clear(o_mem_clear), .o_cfg_bit(o_cfg_bit), .o_cfg_bit_valid(o_cfg_bit_valid),
        .o_frame_ok(o_frame_ok), .o_mode(o_mode));
    cfg_host_model u_cfg_host_model (.i_mclk(i_mclk), .i_go(go), .i_bad(bad), .i_mode(i_mode),
        .i_dev_clk(cfg_w), .i_init_pin(init_w), .i_rdy_busy(o_rdy_busy), .o_cfg_clk(h_clk),
        .o_din(h_din), .o_wr_b(h_wr_b));
    always @(posedge i_mclk) begin
        nfr += int'(o_frame_ok === 1'b1);
        if (o_cfg_bit_valid === 1'b1) begin
            nerr += int'(o_cfg_bit !== ((nbit % 3) == 0));
            nbit++;
        end
        nfall += int'(dout_q === 1'b1 && o_dout === 1'b0);
        dout_q = o_dout;
        if (init_w === 1'b1 && seen === 1'b0) begin
            seen = o_cfg_clk === 1'b1;
            gap += int'(!seen);
        end
    end
    task automatic cmp_v(string nm, logic [23:0] e, logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_n(string nm, int e, int g);
        total_checks++;
        if (g != e) begin
            fails++;
            $display("unexpected %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic complete_run();
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic run(cfg_mode_e m, logic b, logic drv, logic fin);
        @(negedge i_mclk);
        i_restart_b = 1'b0;
        go = 1'b0;
        bad = b;
        i_mode = m;
        repeat (4) @(negedge i_mclk);
        cmp_v("init_oe", 1'b1, o_init_oe);
        cmp_v("done_oe", 1'b1, o_done_oe);
        cmp_v("mem_clear", 1'b1, o_mem_clear);
        repeat (80) @(negedge i_mclk);
        {nfr, nbit, nfall, nerr, gap, seen} = '0;
        i_restart_b = 1'b1;
        go = 1'b1;
        repeat (10) @(negedge i_mclk);
        cmp_v("init_oe", 1'b1, o_init_oe);
        cmp_v("mode", m, o_mode);
        if (fin) begin
            for (t = 0; init_w !== 1'b1 && t < 2000; t++) @(negedge i_mclk);
            cmp_v("init_w", 1'b1, init_w);
            if (m == MODE_APER || m == MODE_SPER) begin
                i_rd_b = 1'b0;
                repeat (4) @(negedge i_mclk);
                cmp_v("din7_oe", 1'b1, o_din7_oe);
                cmp_v("din7", 1'b1, o_din7);
                cmp_v("rdy_busy", 1'b1, o_rdy_busy);
                i_rd_b = 1'b1;
            end
            repeat (200) @(negedge i_mclk);
            cmp_v("clk_oe", drv, o_cfg_clk_oe);
            cmp_v("status_oe", 2'b11, {o_high_oe, o_low_oe});
            cmp_v("status", 2'b10, {o_high_while_loading, o_low_while_loading});
            if (m == MODE_MSER) cmp_n("start_gap", 1, int'(gap >= 10 && gap <= 45));
        end
        for (t = 0; done_w !== 1'b1 && !(b && o_init_oe === 1'b1) && t < 14000; t++) begin
            @(negedge i_mclk);
        end
        cmp_v("done_w", fin && !b, done_w);
        if (fin && !b) begin
            // Let the last chain bit and the synced done level reach the monitors
            repeat (3) @(negedge i_mclk);
            cmp_n("frames", 2, nfr);
            cmp_n("data_bits", 2 * `FRAME_DATA_BITS, nbit);
            cmp_n("bit_errors", 0, nerr);
            cmp_n("dout_falls", 8, nfall);
            cmp_v("high_oe", 1'b0, o_high_oe);
        end
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    initial begin
        #1800000;
        fails++;
        complete_run();
    end
    initial begin
        i_rst_b = 1'b0;
        i_restart_b = 1'b1;
        i_rd_b = 1'b1;
        go = 1'b0;
        bad = 1'b0;
        i_mode = MODE_JTAG;
        repeat (6) @(negedge i_mclk);
        i_rst_b = 1'b1;
        foreach (rows[r]) run(rows[r].m, 1'b0, rows[r].drv, rows[r].fin);
        // Reset in the middle of a configured state
        @(negedge i_mclk);
        i_rst_b = 1'b0;
        repeat (2) @(negedge i_mclk);
        cmp_v("rst_oe", 2'b11, {o_init_oe, o_done_oe});
        cmp_v("rst_clk_oe", 1'b0, o_cfg_clk_oe);
        cmp_v("rst_dout", 1'b1, o_dout);
        i_rst_b = 1'b1;
        run(MODE_SSER, 1'b1, 1'b0, 1'b1);
        cmp_v("err_init_oe", 1'b1, o_init_oe);
        cmp_n("err_frames", 0, nfr);
        repeat (3000) @(negedge i_mclk);
        cmp_v("err_hold", 2'b11, {o_init_oe, o_done_oe});
        complete_run();
    end
endmodule
`default_nettype wire
